// File: design/pmrs_mode_decode.v
// Registered decoder from PHY mode fields to chip rate, shaping, spreading and scrambling
`timescale 1ns/1ps
`default_nettype none
`include "pmrs_regs.vh"

module pmrs_mode_decode
(
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Mode fields
  input  wire [7:0]  mode_cfg,
  // Decoded settings
  output reg         oqpsk,
  output reg  [9:0]  chip_rate_k,
  output reg  [1:0]  tx_shape,
  output reg  [9:0]  psdu_rate_k,
  output reg  [9:0]  header_rate_k,
  output reg  [1:0]  spread_div_log2,
  output reg         scram_on
);

  //----------------------------------------
  // Rate lookup
  //----------------------------------------
  // O-QPSK payload rate by code and chip rate; code 3 falls back to base
  function [9:0] oqpsk_rate;
    input [1:0] code;
    input       hi;
    begin
      case (code)
        2'h1:    oqpsk_rate = hi ? 10'h1f4 : 10'h0c8;
        2'h2:    oqpsk_rate = hi ? 10'h3e8 : 10'h190;
        default: oqpsk_rate = hi ? 10'h0fa : 10'h064;
      endcase
    end
  endfunction

  wire       mod_sel = mode_cfg[`PMRS_BIT_MOD_SEL];    // 1 = O-QPSK
  wire       hi_rate = mode_cfg[`PMRS_BIT_CHIP_RATE];  // 1 = high chip rate
  wire [1:0] rate    = mode_cfg[`PMRS_BIT_RATE_HI:`PMRS_BIT_RATE_LO];

  //----------------------------------------
  // Decode registers
  //----------------------------------------
  // Bits not relevant to the active mode are simply not looked at
  always @(posedge clk)
  begin
    if (rst)
    begin
      oqpsk           <= 1'b0;
      chip_rate_k     <= 10'h258;
      tx_shape        <= `PMRS_SH_RC10;
      psdu_rate_k     <= 10'h028;
      header_rate_k   <= 10'h028;
      spread_div_log2 <= 2'h0;
      scram_on        <= 1'b0;
    end
    else if (!mod_sel)
    begin
      // BPSK both ways, rate bits ignored
      oqpsk           <= 1'b0;
      chip_rate_k     <= hi_rate ? 10'h258 : 10'h12c;  // 600 or 300
      tx_shape        <= `PMRS_SH_RC10;
      psdu_rate_k     <= hi_rate ? 10'h028 : 10'h014;
      header_rate_k   <= hi_rate ? 10'h028 : 10'h014;
      spread_div_log2 <= 2'h0;
      scram_on        <= 1'b0;
    end
    else
    begin
      // O-QPSK both ways
      oqpsk           <= 1'b1;
      chip_rate_k     <= hi_rate ? 10'h3e8 : 10'h190;  // 1000 or 400
      // Shaping is a transmit setting only
      if (hi_rate)
        tx_shape <= mode_cfg[`PMRS_BIT_RC_EN] ? `PMRS_SH_RC08 : `PMRS_SH_SIN;
      else
        tx_shape <= `PMRS_SH_SIN_RC02;
      psdu_rate_k     <= oqpsk_rate(rate, hi_rate);
      header_rate_k   <= oqpsk_rate(2'h0, hi_rate);
      spread_div_log2 <= (rate == 2'h3) ? 2'h0 : rate;
      scram_on        <= mode_cfg[`PMRS_BIT_SCRAM_EN] && (rate == 2'h2);
    end
  end

endmodule
`default_nettype wire

// File: design/pmrs_regs.vh
// Register offsets, field positions, reset values and codes of the PHY mode block
`ifndef PMRS_REGS_VH
`define PMRS_REGS_VH

// Register offsets
`define PMRS_OFS_STATUS     6'h01
`define PMRS_OFS_STATE      6'h02
`define PMRS_OFS_SIG_STR    6'h06
`define PMRS_OFS_ED_LEVEL   6'h07
`define PMRS_OFS_PHY_MODE   6'h0c
`define PMRS_OFS_SYNC_CTL   6'h15
`define PMRS_OFS_PIN_MATCH  6'h19

// Reset values
`define PMRS_RST_PHY_MODE   8'h24
`define PMRS_RST_SYNC_CTL   8'h00
`define PMRS_RST_PIN_MATCH  8'h00

// phy_mode_config fields
`define PMRS_BIT_SAFE_MODE  7
`define PMRS_BIT_AVDD_EN    6
`define PMRS_BIT_SCRAM_EN   5
`define PMRS_BIT_RC_EN      4
`define PMRS_BIT_MOD_SEL    3
`define PMRS_BIT_CHIP_RATE  2
`define PMRS_BIT_RATE_HI    1
`define PMRS_BIT_RATE_LO    0

// sync_detect_control fields
`define PMRS_BIT_PDT_DIS    7
`define PMRS_LVL_HI         3
`define PMRS_LVL_LO         0

// rf_pin_matching fields
`define PMRS_MC_HI          7
`define PMRS_MC_LO          4
`define PMRS_MC_STEP_FF     8'h24

// Threshold step in tenths of a dB (3.1 dB)
`define PMRS_THR_STEP       8'h1f

// FCS valid flag position in signal_strength_register
`define PMRS_BIT_FCS_OK     7

// State commands
`define PMRS_CMD_NOP        5'h00
`define PMRS_CMD_OFF        5'h08
`define PMRS_CMD_PLL_ON     5'h09
`define PMRS_CMD_RX_ON      5'h06
`define PMRS_CMD_AACK_ON    5'h16

// Status codes
`define PMRS_ST_OFF         5'h08
`define PMRS_ST_PLL_ON      5'h09
`define PMRS_ST_RX_ON       5'h06
`define PMRS_ST_BUSY_RX     5'h01
`define PMRS_ST_AACK_ON     5'h16
`define PMRS_ST_BUSY_AACK   5'h11

// Pulse shaping codes
`define PMRS_SH_RC10        2'h0
`define PMRS_SH_SIN         2'h1
`define PMRS_SH_RC08        2'h2
`define PMRS_SH_SIN_RC02    2'h3

`endif

// File: design/pmrs_rx_sync.v
// Sync header acceptance, busy tracking and frame buffer protection
`timescale 1ns/1ps
`default_nettype none
`include "pmrs_regs.vh"

module pmrs_rx_sync
(
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Configuration
  input  wire        listen,
  input  wire        pdt_dis,
  input  wire [3:0]  level,
  input  wire        safe_mode,
  // Demodulator events
  input  wire        shr_found,
  input  wire [7:0]  rssi_tenths,
  input  wire        frame_end,
  input  wire        fcs_ok,
  // Host finished reading the frame
  input  wire        read_done,
  // State
  output reg         busy,
  output reg         protect,
  output reg         frame_stb,
  output wire        accept
);

  //----------------------------------------
  // Acceptance of a new frame
  //----------------------------------------
  wire [8:0] thr    = {5'h00, level} * {1'b0, `PMRS_THR_STEP};  // Floor plus 3.1 dB per step, no wrap
  wire       thr_ok = (level == 4'h0) || ({1'b0, rssi_tenths} >= thr);

  // Listening only; static and dynamic protection both hold the receiver off
  assign accept = listen && !busy && shr_found && !pdt_dis && !protect && thr_ok;

  //----------------------------------------
  // Busy and protection flags
  //----------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      busy      <= 1'b0;
      protect   <= 1'b0;
      frame_stb <= 1'b0;
    end
    else
    begin
      frame_stb <= busy && frame_end;
      // Ongoing frame finishes even if detection is disabled meanwhile
      if (accept)
        busy <= 1'b1;
      else if (frame_end || !listen)
        busy <= 1'b0;                                  // Back to listening
      // Only a frame with good FCS is protected; set wins over clear
      if (busy && frame_end && safe_mode && fcs_ok)
        protect <= 1'b1;
      else if (read_done || !safe_mode)
        protect <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: design/pmrs_top.v
// PHY mode, receive sync control and pin matching register bank
`timescale 1ns/1ps
`default_nettype none
`include "pmrs_regs.vh"

module pmrs_top
(
  // Clock and reset
  input  wire        CLK_SYS,
  input  wire        RST,
  // Register port
  input  wire [5:0]  REG_ADDR,
  input  wire [7:0]  REG_WDATA,
  input  wire        REG_WE,
  input  wire        REG_RE,
  output reg  [7:0]  REG_RDATA,
  // Demodulator events
  input  wire        SHR_FOUND,
  input  wire [7:0]  RSSI_TENTHS,
  input  wire        FRAME_END,
  input  wire        FCS_OK,
  input  wire [7:0]  ED_IN,
  input  wire [7:0]  LQI_IN,
  // Frame read path
  input  wire        FR_START,
  input  wire        FR_STB,
  input  wire        FR_DATA_END,
  input  wire [7:0]  FR_BUF_DATA,
  input  wire        FR_DONE,
  output reg  [7:0]  FR_OUT_DATA,
  // Receiver state
  output wire        RX_DEMOD_EN,
  output wire        RX_ACCEPT,
  output wire        RX_PROTECT,
  output wire        RX_AACK_MODE,
  // PHY settings
  output wire        PHY_OQPSK,
  output wire [9:0]  PHY_CHIP_RATE_K,
  output wire [1:0]  PHY_TX_SHAPE,
  output wire [9:0]  PHY_PSDU_RATE_K,
  output wire [9:0]  PHY_HDR_RATE_K,
  output wire [1:0]  PHY_SPREAD_DIV_LOG2,
  output wire        PHY_SCRAM_ON,
  output wire        PHY_AVDD_EN,
  // RF pin matching
  output wire [3:0]  PIN_MATCH_CODE,
  output reg  [9:0]  PIN_MATCH_FF
);

  //----------------------------------------
  // Transceiver states
  //----------------------------------------
  localparam [1:0] S_OFF  = 2'h0;  // Transceiver off
  localparam [1:0] S_PLL  = 2'h1;  // PLL locked
  localparam [1:0] S_RX   = 2'h2;  // Basic listen
  localparam [1:0] S_AACK = 2'h3;  // Auto-ack listen

  //----------------------------------------
  // Storage
  //----------------------------------------
  reg  [7:0] phy_mode_config;      // Mode fields
  reg  [7:0] sync_detect_control;  // Detect disable and level
  reg  [3:0] pin_match_cap;        // RF pin matching code
  reg  [1:0] state;                // Transceiver state
  reg  [1:0] next_state;           // Next transceiver state
  reg  [7:0] last_ed;              // ED of last frame
  reg  [7:0] last_lqi;             // LQI of last frame
  reg        last_fcs_ok;          // FCS result of last frame
  reg  [1:0] trail_idx;            // Trailer byte index
  reg        frame_read;           // Frame read in progress

  wire       busy;                 // Frame being received
  wire       frame_stb;            // Frame just ended
  wire       listen;               // Receiver listening
  wire [4:0] cmd;                  // Written command
  wire       cmd_wr;               // Command write strobe
  wire [4:0] status_code;          // Status register value

  //----------------------------------------
  // Status encoding
  //----------------------------------------
  // Status code from state and busy flag
  function [4:0] stat_enc;
    input [1:0] st;
    input       bsy;
    begin
      case (st)
        S_PLL:   stat_enc = `PMRS_ST_PLL_ON;
        S_RX:    stat_enc = bsy ? `PMRS_ST_BUSY_RX : `PMRS_ST_RX_ON;
        S_AACK:  stat_enc = bsy ? `PMRS_ST_BUSY_AACK : `PMRS_ST_AACK_ON;
        default: stat_enc = `PMRS_ST_OFF;
      endcase
    end
  endfunction

  assign status_code = stat_enc(state, busy);  // Busy shows while receiving
  assign listen      = (state == S_RX) || (state == S_AACK);
  assign cmd         = REG_WDATA[4:0];
  assign cmd_wr      = REG_WE && (REG_ADDR == `PMRS_OFS_STATE);

  //----------------------------------------
  // Register writes
  //----------------------------------------
  // Mode fields taken at any time; keeping them stable outside off is the host's part
  always @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      phy_mode_config     <= `PMRS_RST_PHY_MODE;  // Rate code zero at reset
      sync_detect_control <= `PMRS_RST_SYNC_CTL;  // Level zero, detection on
      pin_match_cap       <= 4'h0;
    end
    else if (REG_WE)
    begin
      case (REG_ADDR)
        // Mode register
        `PMRS_OFS_PHY_MODE:
          phy_mode_config <= REG_WDATA;
        // Reserved bits 6:4 stay zero
        `PMRS_OFS_SYNC_CTL:
        begin
          sync_detect_control[`PMRS_BIT_PDT_DIS] <= REG_WDATA[`PMRS_BIT_PDT_DIS];
          sync_detect_control[3:0]               <= REG_WDATA[3:0];
        end
        // Pin matching code in the upper nibble
        `PMRS_OFS_PIN_MATCH:
          pin_match_cap <= REG_WDATA[`PMRS_MC_HI:`PMRS_MC_LO];
        // Other offsets ignored
        default:
          pin_match_cap <= pin_match_cap;
      endcase
    end
  end

  //----------------------------------------
  // State command handling
  //----------------------------------------
  // Listen entered only from the documented source states
  always @*
  begin
    next_state = state;
    if (cmd_wr)
    begin
      case (cmd)
        // Basic listen from off or PLL locked
        `PMRS_CMD_RX_ON:
          if (state == S_OFF || state == S_PLL)
            next_state = S_RX;
        // Auto-ack listen from PLL locked only
        `PMRS_CMD_AACK_ON:
          if (state == S_PLL)
            next_state = S_AACK;
        // Lock PLL, also leaves listening
        `PMRS_CMD_PLL_ON:
          next_state = S_PLL;
        // Switch off
        `PMRS_CMD_OFF:
          next_state = S_OFF;
        // Unknown commands do nothing
        default:
          next_state = state;
      endcase
    end
  end

  // State register
  always @(posedge CLK_SYS)
  begin
    if (RST)
      state <= S_OFF;
    else
      state <= next_state;
  end

  //----------------------------------------
  // Sync control
  //----------------------------------------
  pmrs_rx_sync u_sync
  (
    .clk         (CLK_SYS),
    .rst         (RST),
    .listen      (listen),
    .pdt_dis     (sync_detect_control[`PMRS_BIT_PDT_DIS]),
    .level       (sync_detect_control[`PMRS_LVL_HI:`PMRS_LVL_LO]),
    .safe_mode   (phy_mode_config[`PMRS_BIT_SAFE_MODE]),
    .shr_found   (SHR_FOUND),
    .rssi_tenths (RSSI_TENTHS),
    .frame_end   (FRAME_END),
    .fcs_ok      (FCS_OK),
    .read_done   (FR_DONE),
    .busy        (busy),
    .protect     (RX_PROTECT),
    .frame_stb   (frame_stb),
    .accept      (RX_ACCEPT)
  );

  assign RX_DEMOD_EN  = busy;             // Demodulate into buffer
  assign RX_AACK_MODE = (state == S_AACK);

  //----------------------------------------
  // Mode decoding
  //----------------------------------------
  // Same fields drive both directions; nothing is auto-detected
  pmrs_mode_decode u_dec
  (
    .clk             (CLK_SYS),
    .rst             (RST),
    .mode_cfg        (phy_mode_config),
    .oqpsk           (PHY_OQPSK),
    .chip_rate_k     (PHY_CHIP_RATE_K),
    .tx_shape        (PHY_TX_SHAPE),
    .psdu_rate_k     (PHY_PSDU_RATE_K),
    .header_rate_k   (PHY_HDR_RATE_K),
    .spread_div_log2 (PHY_SPREAD_DIV_LOG2),
    .scram_on        (PHY_SCRAM_ON)
  );

  assign PHY_AVDD_EN = phy_mode_config[`PMRS_BIT_AVDD_EN];

  //----------------------------------------
  // Received frame information
  //----------------------------------------
  // Captured as the frame ends
  always @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      last_ed     <= 8'h00;
      last_lqi    <= 8'h00;
      last_fcs_ok <= 1'b0;
    end
    else if (busy && FRAME_END)
    begin
      last_ed     <= ED_IN;
      last_lqi    <= LQI_IN;
      last_fcs_ok <= FCS_OK;
    end
  end

  //----------------------------------------
  // Frame read with trailer
  //----------------------------------------
  // After the data run out, strobes return LQI, ED and status in turn
  always @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      frame_read  <= 1'b0;
      trail_idx   <= 2'h0;
      FR_OUT_DATA <= 8'h00;
    end
    else if (FR_START)
    begin
      frame_read <= 1'b1;
      trail_idx  <= 2'h0;
    end
    else if (FR_DONE)
      frame_read <= 1'b0;
    else if (frame_read && FR_STB)
    begin
      if (!FR_DATA_END)
        FR_OUT_DATA <= FR_BUF_DATA;
      else
      begin
        case (trail_idx)
          2'h0:    FR_OUT_DATA <= last_lqi;
          2'h1:    FR_OUT_DATA <= last_ed;
          2'h2:    FR_OUT_DATA <= {last_fcs_ok, 7'h00};
          default: FR_OUT_DATA <= 8'h00;
        endcase
        if (trail_idx != 2'h3)
          trail_idx <= trail_idx + 2'h1;
      end
    end
  end

  //----------------------------------------
  // Pin matching
  //----------------------------------------
  assign PIN_MATCH_CODE = pin_match_cap;  // Shared by receive and transmit

  // Capacitance per pin in fF
  always @(posedge CLK_SYS)
  begin
    if (RST)
      PIN_MATCH_FF <= 10'h000;
    else
      PIN_MATCH_FF <= pin_match_cap * `PMRS_MC_STEP_FF;
  end

  //----------------------------------------
  // Register reads
  //----------------------------------------
  // Answer one cycle after the read strobe; unmapped offsets read zero
  always @(posedge CLK_SYS)
  begin
    if (RST)
      REG_RDATA <= 8'h00;
    else if (REG_RE)
    begin
      case (REG_ADDR)
        `PMRS_OFS_STATUS:    REG_RDATA <= {3'h0, status_code};
        `PMRS_OFS_STATE:     REG_RDATA <= 8'h00;
        `PMRS_OFS_SIG_STR:   REG_RDATA <= {last_fcs_ok, 7'h00};
        `PMRS_OFS_ED_LEVEL:  REG_RDATA <= last_ed;
        `PMRS_OFS_PHY_MODE:  REG_RDATA <= phy_mode_config;
        `PMRS_OFS_SYNC_CTL:  REG_RDATA <= sync_detect_control;
        `PMRS_OFS_PIN_MATCH: REG_RDATA <= {pin_match_cap, 4'h0};
        default:             REG_RDATA <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

// File: tb/pmrs_host.sv
// Host model driving the register port and frame reads
`timescale 1ns/1ps
`default_nettype none
module pmrs_host
(
  // Clock
  input  wire logic       clk,
  // Register port
  output var  logic [5:0] addr,
  output var  logic [7:0] wdata,
  output var  logic       we,
  output var  logic       re,
  input  wire logic [7:0] rdata,
  // Frame read
  output var  logic       fr_start,
  output var  logic       fr_stb,
  output var  logic       fr_done,
  input  wire logic [7:0] fr_out
);
  initial
  begin
    addr = 6'h00;
    wdata = 8'h00;
    {we, re, fr_start, fr_stb, fr_done} = 5'h00;
  end
  // Write, taken at the edge with we high
  task wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    wdata <= ~v; // Released data shows no stale byte
  endtask
  // Read, answer one cycle after the taken edge
  task rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask
  // Frame read start, or chip select raised at its end
  task fctl(input logic go);
    @(posedge clk);
    fr_start <= go;
    fr_done <= !go;
    @(posedge clk);
    fr_start <= 1'b0;
    fr_done <= 1'b0;
  endtask
  // One frame byte
  task fstb(output logic [7:0] v);
    @(posedge clk);
    fr_stb <= 1'b1;
    @(posedge clk);
    fr_stb <= 1'b0;
    @(posedge clk);
    v = fr_out;
  endtask
endmodule
`default_nettype wire

// File: tb/pmrs_sva.sv
// Port assertions for the PHY mode register bank
`timescale 1ns/1ps
`default_nettype none
module pmrs_sva
(
  // Clock, reset, register port
  input wire logic       CLK_SYS,
  input wire logic       RST,
  input wire logic [5:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WE,
  // Receive side
  input wire logic [7:0] RSSI_TENTHS,
  input wire logic       FRAME_END,
  input wire logic       FCS_OK,
  input wire logic       FR_DONE,
  input wire logic       RX_DEMOD_EN,
  input wire logic       RX_ACCEPT,
  input wire logic       RX_PROTECT,
  // Settings
  input wire logic [9:0] PHY_CHIP_RATE_K,
  input wire logic [1:0] PHY_TX_SHAPE,
  input wire logic [9:0] PHY_PSDU_RATE_K,
  input wire logic       PHY_OQPSK,
  input wire logic       PHY_SCRAM_ON,
  input wire logic [3:0] PIN_MATCH_CODE,
  input wire logic [9:0] PIN_MATCH_FF
);
  reg [7:0] m;  // Mode register shadow
  reg [7:0] md; // Mode as the decoder saw it
  reg [7:0] s;  // Sync control shadow
  // ------
  // Shadows
  // ------
  always @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      m <= 8'h24;
      s <= 8'h00;
    end
    else if (REG_WE && REG_ADDR == 6'h0c)
      m <= REG_WDATA;
    else if (REG_WE && REG_ADDR == 6'h15)
      s <= REG_WDATA;
    md <= m;
  end
  // ------
  // Checks
  // ------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  property p_chip; PHY_CHIP_RATE_K == (md[2] ? (md[3] ? 10'h3e8 : 10'h258) : (md[3] ? 10'h190 : 10'h12c)); endproperty
  a_chip: assert property (p_chip) else $error("chip rate wrong");
  property p_shape; PHY_OQPSK |-> PHY_TX_SHAPE == (md[2] ? {md[4], !md[4]} : 2'h3); endproperty
  a_shape: assert property (p_shape) else $error("shaping wrong");
  property p_psdu; PHY_OQPSK && md[1:0] != 2'h3 |-> PHY_PSDU_RATE_K == ((md[2] ? 10'h0fa : 10'h064) << md[1:0]); endproperty
  a_psdu: assert property (p_psdu) else $error("payload rate wrong");
  property p_scram; PHY_SCRAM_ON == (md[5] && md[3] && md[1:0] == 2'h2); endproperty
  a_scram: assert property (p_scram) else $error("scrambler wrong");
  property p_pin; PIN_MATCH_FF == 10'h024 * $past(PIN_MATCH_CODE); endproperty
  a_pin: assert property (p_pin) else $error("pin capacitance wrong");
  property p_acc; RX_ACCEPT |-> !s[7] && !RX_PROTECT && (s[3:0] == 4'h0 || RSSI_TENTHS >= 10'h01f * s[3:0]); endproperty
  a_acc: assert property (p_acc) else $error("sync accepted wrongly");
  property p_busy; RX_ACCEPT |=> RX_DEMOD_EN; endproperty
  a_busy: assert property (p_busy) else $error("no busy after sync");
  property p_end; RX_DEMOD_EN && FRAME_END |=> !RX_DEMOD_EN; endproperty
  a_end: assert property (p_end) else $error("busy after frame end");
  property p_prot; RX_DEMOD_EN && FRAME_END && FCS_OK && m[7] |=> RX_PROTECT; endproperty
  a_prot: assert property (p_prot) else $error("no protection");
  property p_hold; RX_PROTECT && m[7] && !FR_DONE |=> RX_PROTECT; endproperty
  a_hold: assert property (p_hold) else $error("protection lost");
  c_acc: cover property (RX_ACCEPT);
  c_prot: cover property ($rose(RX_PROTECT));
  c_scram: cover property (PHY_SCRAM_ON);
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench of the PHY mode register bank
`timescale 1ns/1ps
`default_nettype none
`include "pmrs_regs.vh"
module tb;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       shr = 1'b0;
  logic       fend = 1'b0;
  logic       fcs = 1'b0;
  logic       dend = 1'b0;
  logic [7:0] rssi = 8'h00;
  logic [7:0] ed = 8'h00;
  logic [7:0] lqi = 8'h00;
  logic [7:0] bdata = 8'h00;
  wire  [5:0] addr;
  wire  [7:0] wdata, rdata, frout;
  wire        we, re, fst, fsb, fdn, demod, prot, aack, oqpsk, scram, avdd;
  wire  [9:0] chip, psdu, pff, hdr;
  wire  [1:0] shape, sdiv;
  wire  [3:0] pcode;
  logic [7:0] m, d, e, x_ed, x_lqi;
  logic [3:0] lvl;
  int         k;
  int         fails = 0;
  int         cmp_count = 0;
  always #2 clk = ~clk; // 250 MHz
  pmrs_host i_pmrs_host (.clk(clk), .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata),
    .fr_start(fst), .fr_stb(fsb), .fr_done(fdn), .fr_out(frout));
  pmrs_top i_pmrs_top (.CLK_SYS(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WE(we),
    .REG_RE(re), .REG_RDATA(rdata), .SHR_FOUND(shr), .RSSI_TENTHS(rssi), .FRAME_END(fend), .FCS_OK(fcs),
    .ED_IN(ed), .LQI_IN(lqi), .FR_START(fst), .FR_STB(fsb), .FR_DATA_END(dend), .FR_BUF_DATA(bdata),
    .FR_DONE(fdn), .FR_OUT_DATA(frout), .RX_DEMOD_EN(demod), .RX_ACCEPT(), .RX_PROTECT(prot),
    .RX_AACK_MODE(aack), .PHY_OQPSK(oqpsk), .PHY_CHIP_RATE_K(chip), .PHY_TX_SHAPE(shape),
    .PHY_PSDU_RATE_K(psdu), .PHY_HDR_RATE_K(hdr), .PHY_SPREAD_DIV_LOG2(sdiv), .PHY_SCRAM_ON(scram),
    .PHY_AVDD_EN(avdd), .PIN_MATCH_CODE(pcode), .PIN_MATCH_FF(pff));
  // ------
  // Expectations and compares
  // ------
  function automatic logic [9:0] f_chip(input logic [7:0] v);
    f_chip = v[2] ? (v[3] ? 10'h3e8 : 10'h258) : (v[3] ? 10'h190 : 10'h12c);
  endfunction
  function automatic logic [9:0] f_psdu(input logic [7:0] v);
    f_psdu = v[3] ? ((v[2] ? 10'h0fa : 10'h064) << v[1:0]) : (v[2] ? 10'h028 : 10'h014);
  endfunction
  function automatic logic [1:0] f_shape(input logic [7:0] v);
    f_shape = !v[3] ? `PMRS_SH_RC10 : !v[2] ? `PMRS_SH_SIN_RC02 : v[4] ? `PMRS_SH_RC08 : `PMRS_SH_SIN;
  endfunction
  task chk_w(input string n, input logic [9:0] x, input logic [9:0] g);
    cmp_count++;
    if (g !== x)
    begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, x, g);
    end
  endtask
  task chk_b(input string n, input logic [7:0] x, input logic [7:0] g);
    chk_w(n, {2'h0, x}, {2'h0, g});
  endtask
  task chk_f(input string n, input logic x, input logic g);
    chk_w(n, {9'h000, x}, {9'h000, g});
  endtask
  task st(input logic [4:0] x);
    i_pmrs_host.rd(`PMRS_OFS_STATUS, e);
    chk_b("status", {3'h0, x}, e & 8'h1f);
  endtask
  // Demodulator events, settled check at the following low phase
  task ev(input logic s, input logic f, input logic ok, input logic [7:0] r);
    @(posedge clk);
    if (f)
    begin
      x_ed = 8'($urandom);
      x_lqi = 8'($urandom);
    end
    shr <= s;
    fend <= f;
    fcs <= ok;
    rssi <= r;
    ed <= x_ed;
    lqi <= x_lqi;
    @(posedge clk);
    shr <= 1'b0;
    fend <= 1'b0;
    fcs <= ~ok;
    @(negedge clk);
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict;
  end
  // ------
  // Main sequence
  // ------
  initial
  begin
    void'($urandom(32'h5000));
    x_ed = 8'h00;
    x_lqi = 8'h00;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    i_pmrs_host.rd(`PMRS_OFS_PHY_MODE, d);
    chk_b("mode reset", `PMRS_RST_PHY_MODE, d);
    i_pmrs_host.rd(`PMRS_OFS_SYNC_CTL, d);
    chk_b("sync reset", `PMRS_RST_SYNC_CTL, d);
    // Every modulation, chip rate, rate codes 0 to 2 and shaping bit; still off
    for (k = 0; k < 24; k++)
    begin
      m = {1'b0, 1'($urandom), 1'($urandom), 1'(k / 12), 1'(k / 6 % 2), 1'(k / 3 % 2), 2'(k % 3)};
      i_pmrs_host.wr(`PMRS_OFS_PHY_MODE, m);
      i_pmrs_host.rd(`PMRS_OFS_PHY_MODE, d);
      chk_b("mode", m, d);
      chk_f("oqpsk", m[3], oqpsk);
      chk_f("avdd", m[6], avdd);
      chk_w("chip", f_chip(m), chip);
      chk_w("psdu", f_psdu(m), psdu);
      chk_f("scram", m[5] & m[3] & (m[1:0] == 2'h2), scram);
      chk_w("shape", {8'h00, f_shape(m)}, {8'h00, shape});
      chk_w("hdr", f_psdu(m & 8'hfc), hdr);
      chk_w("spread", {8'h00, m[3] ? m[1:0] : 2'h0}, {8'h00, sdiv});
    end
    for (k = 0; k < 16; k++)
    begin
      m = {4'(k), 4'($urandom)};
      i_pmrs_host.wr(`PMRS_OFS_PIN_MATCH, m);
      i_pmrs_host.rd(`PMRS_OFS_PIN_MATCH, d);
      chk_b("pin reg", m & 8'hf0, d);
      chk_w("pin ff", 10'h024 * 10'(k), pff);
      chk_w("pin code", 10'(k), {6'h00, pcode});
    end
    m = 8'($urandom);
    i_pmrs_host.wr(`PMRS_OFS_SYNC_CTL, m);
    i_pmrs_host.rd(`PMRS_OFS_SYNC_CTL, d);
    chk_b("sync reg", m & 8'h8f, d);
    i_pmrs_host.rd(6'h3f, d);
    chk_b("unmapped", 8'h00, d);
    // Listen with safe mode and a threshold
    i_pmrs_host.wr(`PMRS_OFS_PHY_MODE, `PMRS_RST_PHY_MODE | 8'h80);
    lvl = 4'(1 + $urandom % 8);
    i_pmrs_host.wr(`PMRS_OFS_SYNC_CTL, {4'h0, lvl});
    i_pmrs_host.wr(`PMRS_OFS_STATE, {3'h0, `PMRS_CMD_RX_ON});
    st(`PMRS_ST_RX_ON);
    ev(1'b1, 1'b0, 1'b0, 8'(10'h01f * lvl - 10'h001));
    chk_f("weak", 1'b0, demod);
    ev(1'b1, 1'b0, 1'b0, 8'(10'h01f * lvl));
    chk_f("busy", 1'b1, demod);
    st(`PMRS_ST_BUSY_RX);
    ev(1'b0, 1'b1, 1'b1, 8'h00);
    chk_f("idle", 1'b0, demod);
    chk_f("protect", 1'b1, prot);
    i_pmrs_host.rd(`PMRS_OFS_ED_LEVEL, d);
    chk_b("ed reg", x_ed, d);
    i_pmrs_host.rd(`PMRS_OFS_SIG_STR, d);
    chk_f("fcs reg", 1'b1, d[7]);
    ev(1'b1, 1'b0, 1'b0, 8'hff);
    chk_f("protected", 1'b0, demod);
    // Frame read with trailer
    i_pmrs_host.fctl(1'b1);
    m = 8'($urandom);
    bdata <= m;
    i_pmrs_host.fstb(d);
    chk_b("frame byte", m, d);
    dend <= 1'b1;
    i_pmrs_host.fstb(d);
    chk_b("lqi", x_lqi, d);
    i_pmrs_host.fstb(d);
    chk_b("ed", x_ed, d);
    i_pmrs_host.fstb(d);
    chk_b("rx status", 8'h80, d);
    i_pmrs_host.fctl(1'b0);
    ev(1'b0, 1'b0, 1'b0, 8'hff);
    chk_f("released", 1'b0, prot);
    // Bad frame, then detect disable in mid-frame
    ev(1'b1, 1'b0, 1'b0, 8'hff);
    ev(1'b0, 1'b1, 1'b0, 8'hff);
    chk_f("bad fcs", 1'b0, prot);
    ev(1'b1, 1'b0, 1'b0, 8'hff);
    i_pmrs_host.wr(`PMRS_OFS_SYNC_CTL, {4'h8, lvl});
    ev(1'b0, 1'b0, 1'b0, 8'hff);
    chk_f("running", 1'b1, demod);
    ev(1'b0, 1'b1, 1'b0, 8'hff);
    ev(1'b1, 1'b0, 1'b0, 8'hff);
    chk_f("disabled", 1'b0, demod);
    // Auto-ack listen from the locked state
    i_pmrs_host.wr(`PMRS_OFS_STATE, {3'h0, `PMRS_CMD_OFF});
    i_pmrs_host.wr(`PMRS_OFS_STATE, {3'h0, `PMRS_CMD_PLL_ON});
    i_pmrs_host.wr(`PMRS_OFS_STATE, {3'h0, `PMRS_CMD_AACK_ON});
    st(`PMRS_ST_AACK_ON);
    chk_f("aack", 1'b1, aack);
    i_pmrs_host.wr(`PMRS_OFS_SYNC_CTL, 8'h00);
    ev(1'b1, 1'b0, 1'b0, 8'h00);
    st(`PMRS_ST_BUSY_AACK);
    print_verdict;
  end
endmodule
bind pmrs_top pmrs_sva i_pmrs_sva (.CLK_SYS(CLK_SYS), .RST(RST), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .RSSI_TENTHS(RSSI_TENTHS), .FRAME_END(FRAME_END),
  .FCS_OK(FCS_OK), .FR_DONE(FR_DONE), .RX_DEMOD_EN(RX_DEMOD_EN), .RX_ACCEPT(RX_ACCEPT),
  .RX_PROTECT(RX_PROTECT), .PHY_CHIP_RATE_K(PHY_CHIP_RATE_K), .PHY_TX_SHAPE(PHY_TX_SHAPE),
  .PHY_PSDU_RATE_K(PHY_PSDU_RATE_K), .PHY_OQPSK(PHY_OQPSK), .PHY_SCRAM_ON(PHY_SCRAM_ON),
  .PIN_MATCH_CODE(PIN_MATCH_CODE), .PIN_MATCH_FF(PIN_MATCH_FF));
`default_nettype wire
